// file: rtl/rli_pkg.sv
// constants, types and register map of the reference-loss / input block
// assumes one 40 MHz control clock and APB register access
`default_nettype none
package rli_pkg;

    // apb byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_TIMEOUT  = 8'h04;
    localparam logic [7:0] OFF_VMIN     = 8'h08;
    localparam logic [7:0] OFF_IMIN     = 8'h0C;
    localparam logic [7:0] OFF_PMIN     = 8'h10;
    localparam logic [7:0] OFF_FUNC_LO  = 8'h14;
    localparam logic [7:0] OFF_FUNC_HI  = 8'h18;
    localparam logic [7:0] OFF_FILTER   = 8'h1C;
    localparam logic [7:0] OFF_JOG      = 8'h20;
    localparam logic [7:0] OFF_LEVELS   = 8'h24;
    localparam logic [7:0] OFF_LOSS     = 8'h28;
    localparam logic [7:0] OFF_REF      = 8'h2C;

    // control register field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_CRIT_LSB = 4;
    localparam int CTRL_ACT_LSB  = 6;

    // reset values
    localparam logic [15:0] RST_TIMEOUT = 16'h000A; // 1.0 sec in 0.1 s
    localparam logic [15:0] RST_FILTER  = 16'h000F; // 15 ms
    localparam logic [15:0] RST_JOG     = 16'h03E8; // 10.00 Hz
    localparam logic [11:0] RST_VMIN    = 12'h000;
    localparam logic [11:0] RST_IMIN    = 12'h000;
    localparam logic [11:0] RST_PMIN    = 12'h000;

    // timing
    localparam int CLK_PERIOD_NS  = 25;
    localparam int MS_NS          = 1000000;
    localparam int MS_TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int MS_PER_TENTH   = 100;

    typedef enum logic [3:0] {
        MODE_KEYPAD1 = 4'h0, MODE_KEYPAD2 = 4'h1,
        MODE_VOLT    = 4'h2, MODE_UNIPOLAR_VOLT = 4'h3,
        MODE_CURR    = 4'h4, MODE_VOLT_PLUS_CURR = 4'h5,
        MODE_PULSE   = 4'h6, MODE_SERIAL  = 4'h7,
        MODE_EXT_PID = 4'h8
    } rli_mode_e;

    typedef enum logic [1:0] {
        CRIT_NONE = 2'h0, CRIT_HALF_MIN = 2'h1, CRIT_BELOW_MIN = 2'h2
    } rli_crit_e;

    typedef enum logic [1:0] {
        ACT_NONE = 2'h0, ACT_COAST = 2'h1, ACT_STOP = 2'h2
    } rli_act_e;

    typedef enum logic [1:0] {
        LOSS_NONE = 2'h0, LOSS_VOLT = 2'h1,
        LOSS_CURR = 2'h2, LOSS_PULSE = 2'h3
    } rli_loss_e;

    // input function codes, selectable per programmable input
    localparam int NFUNC = 35;
    localparam logic [5:0] FN_SPEED_L = 6'h00, FN_SPEED_M = 6'h01;
    localparam logic [5:0] FN_SPEED_H = 6'h02, FN_RAMP_SEL0 = 6'h03;
    localparam logic [5:0] FN_EXCHANGE = 6'h08, FN_ANALOG_HOLD = 6'h12;
    localparam logic [5:0] FN_RAMP_INHIBIT = 6'h13, FN_SPEED_X = 6'h1A;
    localparam logic [5:0] FN_RESET = 6'h1B, FN_ESTOP = 6'h1C;
    localparam logic [5:0] FN_JOG = 6'h1D, FN_FWD = 6'h1E;
    localparam logic [5:0] FN_REV = 6'h1F;
    localparam logic [47:0] RST_FUNC_SEL = {FN_REV, FN_FWD, FN_JOG,
        FN_ESTOP, FN_RESET, FN_SPEED_H, FN_SPEED_M, FN_SPEED_L};

    typedef struct packed {
        rli_act_e  act;
        rli_crit_e crit;
        rli_mode_e mode;
    } rli_ctrl_s;

endpackage : rli_pkg
`default_nettype wire

// file: rtl/rli_top.sv
// reference-loss supervisor and programmable input terminal conditioner
// assumes: analog/pulse levels come from converters on CLK; terminal pins
// are asynchronous; software reaches the registers over apb
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rli_top #(
    parameter int MS_TICK_CYCLES = rli_pkg::MS_TICK_CYCLES,
    parameter int LEVEL_W        = 12
) (
    // clock and reset
    input  wire logic                      CLK,
    input  wire logic                      RST,
    // apb slave
    input  wire logic                      PSEL,
    input  wire logic                      PENABLE,
    input  wire logic                      PWRITE,
    input  wire logic [7:0]                PADDR,
    input  wire logic [31:0]               PWDATA,
    output logic [31:0]                    PRDATA,
    output logic                           PREADY,
    output logic                           PSLVERR,
    // field terminals
    input  wire logic [7:0]                PROG_IN,
    input  wire logic [2:0]                SUB_IN,
    input  wire logic                      SUBBOARD_PRESENT,
    // reference levels from converters
    input  wire logic [LEVEL_W-1:0]        VOLT_LEVEL,
    input  wire logic [LEVEL_W-1:0]        CURR_LEVEL,
    input  wire logic [LEVEL_W-1:0]        PULSE_LEVEL,
    // drive control
    output logic                           OUTPUT_DRIVE_ON,
    output logic                           DECEL_STOP_REQ,
    output logic [1:0]                     LOSS_CODE,
    output logic                           RAMP_INHIBIT,
    output logic                           JOG_ACTIVE,
    output logic [3:0]                     SPEED_STEP,
    output logic [15:0]                    FREQ_REF,
    output logic [rli_pkg::NFUNC-1:0]      FUNC_ACTIVE,
    output logic [10:0]                    SUB_FUNC_LEVELS
);

    generate
        if (MS_TICK_CYCLES < 2 || LEVEL_W < 2 || LEVEL_W > 16) begin : g_chk
            $error("rli_top: unsupported parameter value");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // registers
    rli_pkg::rli_ctrl_s   ctrl_ff;
    logic [15:0]          timeout_ff;
    logic [LEVEL_W-1:0]   vmin_ff;
    logic [LEVEL_W-1:0]   imin_ff;
    logic [LEVEL_W-1:0]   pmin_ff;
    logic [47:0]          func_sel_ff;
    logic [15:0]          filter_ff;
    logic [15:0]          jog_ff;
    logic [31:0]          nxt_prdata;
    logic [31:0]          prdata_ff;
    logic                 mapped;
    logic                 writable;
    logic                 estop_on;
    logic                 wr_ok;
    logic [10:0]          levels;
    logic                 declared_ff;
    rli_pkg::rli_loss_e   src_ff;
    logic [LEVEL_W-1:0]   analog_ff;

    assign PREADY  = 1'b1;
    assign PRDATA  = prdata_ff;
    assign PSLVERR = PSEL && PENABLE && (!mapped || (PWRITE && !wr_ok));
    assign wr_ok   = writable && !estop_on;

    always_comb begin
        mapped     = 1'b1;
        writable   = 1'b1;
        nxt_prdata = 32'h0000_0000;
        if (PADDR == rli_pkg::OFF_CTRL) begin
            nxt_prdata = {24'h00_0000, ctrl_ff};
        end else if (PADDR == rli_pkg::OFF_TIMEOUT) begin
            nxt_prdata = {16'h0000, timeout_ff};
        end else if (PADDR == rli_pkg::OFF_VMIN) begin
            nxt_prdata = 32'(vmin_ff);
        end else if (PADDR == rli_pkg::OFF_IMIN) begin
            nxt_prdata = 32'(imin_ff);
        end else if (PADDR == rli_pkg::OFF_PMIN) begin
            nxt_prdata = 32'(pmin_ff);
        end else if (PADDR == rli_pkg::OFF_FUNC_LO) begin
            nxt_prdata = {2'b00, func_sel_ff[23:18], 2'b00,
                func_sel_ff[17:12], 2'b00, func_sel_ff[11:6],
                2'b00, func_sel_ff[5:0]};
        end else if (PADDR == rli_pkg::OFF_FUNC_HI) begin
            nxt_prdata = {2'b00, func_sel_ff[47:42], 2'b00,
                func_sel_ff[41:36], 2'b00, func_sel_ff[35:30],
                2'b00, func_sel_ff[29:24]};
        end else if (PADDR == rli_pkg::OFF_FILTER) begin
            nxt_prdata = {16'h0000, filter_ff};
        end else if (PADDR == rli_pkg::OFF_JOG) begin
            nxt_prdata = {16'h0000, jog_ff};
        end else if (PADDR == rli_pkg::OFF_LEVELS) begin
            writable   = 1'b0;
            nxt_prdata = {21'h00_0000, levels};
        end else if (PADDR == rli_pkg::OFF_LOSS) begin
            writable   = 1'b0;
            nxt_prdata = {29'h0000_0000, declared_ff, src_ff};
        end else if (PADDR == rli_pkg::OFF_REF) begin
            writable   = 1'b0;
            nxt_prdata = 32'(analog_ff);
        end else begin
            mapped   = 1'b0;
            writable = 1'b0;
        end
    end

    // read data is captured in the setup cycle so the access cycle needs
    // no wait state and PRDATA still comes from a flop
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            prdata_ff <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            prdata_ff <= nxt_prdata;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_ff     <= '{rli_pkg::ACT_NONE, rli_pkg::CRIT_NONE,
                             rli_pkg::MODE_KEYPAD1};
            timeout_ff  <= rli_pkg::RST_TIMEOUT;
            vmin_ff     <= LEVEL_W'(rli_pkg::RST_VMIN);
            imin_ff     <= LEVEL_W'(rli_pkg::RST_IMIN);
            pmin_ff     <= LEVEL_W'(rli_pkg::RST_PMIN);
            func_sel_ff <= rli_pkg::RST_FUNC_SEL;
            filter_ff   <= rli_pkg::RST_FILTER;
            jog_ff      <= rli_pkg::RST_JOG;
        end else if (PSEL && PENABLE && PWRITE && wr_ok) begin
            if (PADDR == rli_pkg::OFF_CTRL) begin
                ctrl_ff <= rli_pkg::rli_ctrl_s'(PWDATA[7:0]);
            end else if (PADDR == rli_pkg::OFF_TIMEOUT) begin
                timeout_ff <= PWDATA[15:0];
            end else if (PADDR == rli_pkg::OFF_VMIN) begin
                vmin_ff <= PWDATA[LEVEL_W-1:0];
            end else if (PADDR == rli_pkg::OFF_IMIN) begin
                imin_ff <= PWDATA[LEVEL_W-1:0];
            end else if (PADDR == rli_pkg::OFF_PMIN) begin
                pmin_ff <= PWDATA[LEVEL_W-1:0];
            end else if (PADDR == rli_pkg::OFF_FUNC_LO) begin
                func_sel_ff[23:0] <= {PWDATA[29:24], PWDATA[21:16],
                                      PWDATA[13:8], PWDATA[5:0]};
            end else if (PADDR == rli_pkg::OFF_FUNC_HI) begin
                func_sel_ff[47:24] <= {PWDATA[29:24], PWDATA[21:16],
                                       PWDATA[13:8], PWDATA[5:0]};
            end else if (PADDR == rli_pkg::OFF_FILTER) begin
                filter_ff <= PWDATA[15:0];
            end else if (PADDR == rli_pkg::OFF_JOG) begin
                jog_ff <= PWDATA[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // millisecond tick
    logic [$clog2(MS_TICK_CYCLES)-1:0] div_ff;
    logic                              ms_tick;

    assign ms_tick = (div_ff == ($clog2(MS_TICK_CYCLES))'(MS_TICK_CYCLES - 1));

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            div_ff <= '0;
        end else if (ms_tick) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // terminal synchronise and filter
    logic [10:0] raw_meta_ff;
    logic [10:0] raw_ff;
    logic [1:0]  sub_sync_ff;
    logic [10:0] filt;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            raw_meta_ff <= 11'h000;
            raw_ff      <= 11'h000;
            sub_sync_ff <= 2'b00;
        end else begin
            raw_meta_ff <= {SUB_IN, PROG_IN};
            raw_ff      <= raw_meta_ff;
            sub_sync_ff <= {sub_sync_ff[0], SUBBOARD_PRESENT};
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 11; gi++) begin : g_filt
            logic        last_ff;
            logic        out_ff;
            logic [15:0] cnt_ff;

            // a raw change restarts the count, so only a level that held
            // for the whole filter time gets through
            always_ff @(posedge CLK or posedge RST) begin
                if (RST) begin
                    last_ff <= 1'b0;
                    cnt_ff  <= 16'h0000;
                end else if (raw_ff[gi] != last_ff) begin
                    last_ff <= raw_ff[gi];
                    cnt_ff  <= 16'h0000;
                end else if (ms_tick && cnt_ff < filter_ff) begin
                    cnt_ff <= cnt_ff + 16'h0001;
                end
            end

            always_ff @(posedge CLK or posedge RST) begin
                if (RST) begin
                    out_ff <= 1'b0;
                end else if (cnt_ff >= filter_ff) begin
                    out_ff <= last_ff;
                end
            end
            assign filt[gi] = out_ff;
        end
    endgenerate

    // sub-board bits read zero and are unused without the sub-board
    assign levels = {filt[10:8] & {3{sub_sync_ff[1]}}, filt[7:0]};
    assign SUB_FUNC_LEVELS = levels;

    ////////////////////////////////////////////////////////////////////////
    // function decode
    logic [rli_pkg::NFUNC-1:0] func_act;

    always_comb begin
        func_act = '0;
        for (int i = 0; i < 8; i++) begin
            if (filt[i] && func_sel_ff[6*i +: 6] < 6'(rli_pkg::NFUNC)) begin
                func_act[func_sel_ff[6*i +: 6]] = 1'b1;
            end
        end
    end

    assign FUNC_ACTIVE  = func_act;
    assign estop_on     = func_act[rli_pkg::FN_ESTOP];
    assign RAMP_INHIBIT = func_act[rli_pkg::FN_RAMP_INHIBIT];
    assign JOG_ACTIVE   = func_act[rli_pkg::FN_JOG];
    assign SPEED_STEP   = JOG_ACTIVE ? 4'h0 :
        {func_act[rli_pkg::FN_SPEED_X], func_act[rli_pkg::FN_SPEED_H],
         func_act[rli_pkg::FN_SPEED_M], func_act[rli_pkg::FN_SPEED_L]};
    // above: jog masks the step index, speed-low is its lsb

    ////////////////////////////////////////////////////////////////////////
    // reference-loss supervision
    logic                  sup_on;
    logic [LEVEL_W-1:0]    act_level;
    logic [LEVEL_W-1:0]    act_min;
    rli_pkg::rli_loss_e    act_src;
    logic                  below;
    logic [23:0]           loss_cnt_ff;
    logic [23:0]           limit_ms;

    always_comb begin
        sup_on    = 1'b1;
        act_level = VOLT_LEVEL;
        act_min   = vmin_ff;
        act_src   = rli_pkg::LOSS_VOLT;
        case (ctrl_ff.mode)
            rli_pkg::MODE_VOLT, rli_pkg::MODE_UNIPOLAR_VOLT,
            rli_pkg::MODE_VOLT_PLUS_CURR: begin
                act_src = rli_pkg::LOSS_VOLT;
            end
            rli_pkg::MODE_CURR: begin
                act_level = CURR_LEVEL;
                act_min   = imin_ff;
                act_src   = rli_pkg::LOSS_CURR;
            end
            rli_pkg::MODE_PULSE: begin
                act_level = PULSE_LEVEL;
                act_min   = pmin_ff;
                act_src   = rli_pkg::LOSS_PULSE;
            end
            default: begin
                sup_on = 1'b0;
            end
        endcase
    end

    always_comb begin
        case (ctrl_ff.crit)
            rli_pkg::CRIT_HALF_MIN:  below = act_level < (act_min >> 1);
            rli_pkg::CRIT_BELOW_MIN: below = act_level < act_min;
            default:                 below = 1'b0;
        endcase
        below = below && sup_on;
    end

    assign limit_ms = 24'(timeout_ff * 16'(rli_pkg::MS_PER_TENTH));

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            loss_cnt_ff <= 24'h00_0000;
        end else if (!below) begin
            loss_cnt_ff <= 24'h00_0000;
        end else if (ms_tick && loss_cnt_ff < limit_ms) begin
            loss_cnt_ff <= loss_cnt_ff + 24'h00_0001;
        end
    end

    // loss stays declared only while the input stays below threshold
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            declared_ff <= 1'b0;
            src_ff      <= rli_pkg::LOSS_NONE;
        end else if (below && loss_cnt_ff >= limit_ms) begin
            declared_ff <= 1'b1;
            src_ff      <= act_src;
        end else if (!below) begin
            declared_ff <= 1'b0;
            src_ff      <= rli_pkg::LOSS_NONE;
        end
    end

    assign LOSS_CODE = src_ff;
    assign OUTPUT_DRIVE_ON = !(declared_ff &&
        ctrl_ff.act == rli_pkg::ACT_COAST);
    assign DECEL_STOP_REQ = declared_ff &&
        ctrl_ff.act == rli_pkg::ACT_STOP;

    ////////////////////////////////////////////////////////////////////////
    // analog reference hold and output reference
    logic [15:0] freq_ff;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            analog_ff <= '0;
        end else if (!func_act[rli_pkg::FN_ANALOG_HOLD]) begin
            analog_ff <= act_level;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            freq_ff <= 16'h0000;
        end else if (JOG_ACTIVE) begin
            freq_ff <= jog_ff;
        end else begin
            freq_ff <= 16'(analog_ff);
        end
    end

    assign FREQ_REF = freq_ff;

endmodule : rli_top
`default_nettype wire

// file: verif/rli_checker.sv
// assertions on the rli_top ports
// assumes one clock, RST asynchronous and active high
`timescale 1ns/1ps
`default_nettype none
module rli_checker (
    // clock and reset
    input wire logic                      CLK,
    input wire logic                      RST,
    // apb
    input wire logic                      PSEL,
    input wire logic                      PENABLE,
    input wire logic                      PWRITE,
    input wire logic [7:0]                PADDR,
    input wire logic [31:0]               PRDATA,
    input wire logic                      PREADY,
    input wire logic                      PSLVERR,
    // drive control
    input wire logic                      OUTPUT_DRIVE_ON,
    input wire logic                      DECEL_STOP_REQ,
    input wire logic [1:0]                LOSS_CODE,
    input wire logic                      RAMP_INHIBIT,
    input wire logic                      JOG_ACTIVE,
    input wire logic [3:0]                SPEED_STEP,
    input wire logic [rli_pkg::NFUNC-1:0] FUNC_ACTIVE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_acc; PSEL && PENABLE; endsequence
    sequence s_wr; PSEL && PENABLE && PWRITE; endsequence
    ////////////////////////////////////////////////////////////////////
    chk_zero_wait: assert property (s_acc |-> PREADY)
        else $error("access phase without ready");
    chk_ro_refused: assert property (
        s_wr ##0 (PADDR inside {8'h24, 8'h28, 8'h2C}) |-> PSLVERR)
        else $error("read-only write not refused");
    chk_unmapped_read: assert property (
        s_acc ##0 (!PWRITE && PADDR > 8'h2C) |-> PSLVERR && PRDATA == 0)
        else $error("unmapped read not refused");
    chk_estop_lock: assert property (
        s_wr ##0 FUNC_ACTIVE[28] |-> PSLVERR)
        else $error("write accepted during emergency stop");
    chk_jog_first: assert property (JOG_ACTIVE |-> SPEED_STEP == 4'h0)
        else $error("step index not zero during jog");
    chk_step_bits: assert property (!JOG_ACTIVE |-> SPEED_STEP ==
        {FUNC_ACTIVE[26], FUNC_ACTIVE[2], FUNC_ACTIVE[1], FUNC_ACTIVE[0]})
        else $error("step index does not follow speed bits");
    chk_inhibit_map: assert property (
        $rose(FUNC_ACTIVE[19]) |-> ##[0:1] RAMP_INHIBIT)
        else $error("ramp inhibit not raised");
    chk_coast_cause: assert property (!OUTPUT_DRIVE_ON |->
        LOSS_CODE != 2'h0 || $past(LOSS_CODE) != 2'h0)
        else $error("output drive off without loss");
    chk_stop_cause: assert property (DECEL_STOP_REQ |-> OUTPUT_DRIVE_ON &&
        (LOSS_CODE != 2'h0 || $past(LOSS_CODE) != 2'h0))
        else $error("stop request without loss");
endmodule : rli_checker
bind rli_top rli_checker i_chk (.CLK(CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .OUTPUT_DRIVE_ON(OUTPUT_DRIVE_ON),
    .DECEL_STOP_REQ(DECEL_STOP_REQ), .LOSS_CODE(LOSS_CODE),
    .RAMP_INHIBIT(RAMP_INHIBIT), .JOG_ACTIVE(JOG_ACTIVE),
    .SPEED_STEP(SPEED_STEP), .FUNC_ACTIVE(FUNC_ACTIVE));
`default_nettype wire

// file: verif/rli_field.sv
// field side: contacts, sub-board and converter levels
// assumes callers act just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module rli_field (
    // terminals
    output logic [7:0]  prog_in,
    output logic [2:0]  sub_in,
    output logic        present,
    // converter levels
    output logic [11:0] volt,
    output logic [11:0] curr,
    output logic [11:0] pulse
);
    // levels start healthy so no loss is pending at power-up
    initial begin
        prog_in = 8'h00;
        sub_in  = 3'h0;
        present = 1'b0;
        volt    = 12'hFFF;
        curr    = 12'hFFF;
        pulse   = 12'hFFF;
    end
    task automatic set_in(input logic [7:0] p, input logic [2:0] s,
                          input logic pr);
        prog_in <= p;
        sub_in  <= s;
        present <= pr;
    endtask : set_in
    task automatic set_lv(input logic [11:0] v, c, pl);
        volt  <= v;
        curr  <= c;
        pulse <= pl;
    endtask : set_lv
endmodule : rli_field
`default_nettype wire

// file: verif/rli_top_bench.sv
// self-checking bench for rli_top with a shortened millisecond tick
// assumes rli_field drives terminals and levels, rli_checker is bound
`timescale 1ns/1ps
`default_nettype none
module rli_top_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, drive_on, decel, ramp_inh, jog;
    logic [1:0]  loss;
    logic [3:0]  step;
    logic [15:0] freq;
    logic [34:0] func;
    logic [10:0] lvls;
    logic [7:0]  prog;
    logic [2:0]  sub;
    logic        pres;
    logic [11:0] volt, curr, pulse;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    rli_top #(.MS_TICK_CYCLES(4)) i_dut (.CLK(clk), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PROG_IN(prog),
        .SUB_IN(sub), .SUBBOARD_PRESENT(pres), .VOLT_LEVEL(volt),
        .CURR_LEVEL(curr), .PULSE_LEVEL(pulse), .OUTPUT_DRIVE_ON(drive_on),
        .DECEL_STOP_REQ(decel), .LOSS_CODE(loss), .RAMP_INHIBIT(ramp_inh),
        .JOG_ACTIVE(jog), .SPEED_STEP(step), .FREQ_REF(freq),
        .FUNC_ACTIVE(func), .SUB_FUNC_LEVELS(lvls));
    rli_field i_fld (.prog_in(prog), .sub_in(sub), .present(pres),
        .volt(volt), .curr(curr), .pulse(pulse));
    ////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    task automatic check(input string nm, input logic [63:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    // one idle cycle before each setup keeps drives one per time step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), 64'(rd), 64'(exp));
    endtask : rdc
    ////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'(rli_pkg::RST_TIMEOUT));
        rdc(8'h1C, 32'(rli_pkg::RST_FILTER));
        rdc(8'h20, 32'(rli_pkg::RST_JOG));
        rdc(8'h14, 32'h1B020100);
        rdc(8'h18, 32'h1F1E1D1C);
        rdc(8'h24, 32'h0);
        wr(8'h24, 32'h7FF);
        check("ro write", 64'(err), 64'h1);
        rdc(8'h40, 32'h0);
        check("unmapped", 64'(err), 64'h1);
    endtask : t_regs
    task automatic t_levels();
        wr(8'h1C, 32'h5);
        i_fld.set_in(8'h05, 3'h7, 1'b0);
        wt(8);
        i_fld.set_in(8'h00, 3'h7, 1'b0);
        wt(40);
        check("glitch", 64'(lvls), 64'h0);
        i_fld.set_in(8'h05, 3'h7, 1'b0);
        wt(40);
        check("no sub", 64'(lvls), 64'h005);
        check("step", 64'(step), 64'h5);
        i_fld.set_in(8'h05, 3'h7, 1'b1);
        wt(40);
        rdc(8'h24, 32'h705);
        i_fld.set_in(8'h00, 3'h0, 1'b1);
        wt(40);
    endtask : t_levels
    task automatic t_jog();
        wr(8'h20, 32'h0100);
        i_fld.set_in(8'h27, 3'h0, 1'b1);
        wt(40);
        check("jog", 64'(jog), 64'h1);
        check("jog step", 64'(step), 64'h0);
        check("jog freq", 64'(freq), 64'h0100);
        i_fld.set_in(8'h10, 3'h0, 1'b1);
        wt(40);
        wr(8'h20, 32'h0200);
        check("locked", 64'(err), 64'h1);
        i_fld.set_in(8'h00, 3'h0, 1'b1);
        wt(40);
        rdc(8'h20, 32'h0100);
    endtask : t_jog
    task automatic t_funcs();
        wr(8'h1C, 32'd101);
        i_fld.set_in(8'h01, 3'h0, 1'b1);
        wt(430);
        for (int c = 0; c < rli_pkg::NFUNC; c++) begin
            if (c == 28) continue;
            wr(8'h14, {24'h1B0201, 8'(c)});
            wt(4);
            check("func", 64'(func), 64'h1 << c);
            check("inhibit", 64'(ramp_inh), 64'(c == 19));
        end
        wr(8'h14, 32'h1B02013F);
        wt(4);
        check("no func", 64'(func), 64'h0);
        wr(8'h00, 32'h02);
        i_fld.set_lv(12'h123, 12'hFFF, 12'hFFF);
        wt(10);
        rdc(8'h2C, 32'h123);
        wr(8'h14, 32'h1B020112);
        wt(4);
        i_fld.set_lv(12'h456, 12'hFFF, 12'hFFF);
        wt(10);
        rdc(8'h2C, 32'h123);
        check("hold freq", 64'(freq), 64'h123);
        wr(8'h14, 32'h1B020100);
        wr(8'h1C, 32'h1);
        i_fld.set_in(8'h00, 3'h0, 1'b1);
        wt(40);
    endtask : t_funcs
    // control byte is {action, criterion, mode}; minimum points are 0x100
    task automatic t_loss();
        logic [7:0]  ctl [10] = '{8'h62, 8'h94, 8'h26, 8'h65, 8'h60,
                                  8'h42, 8'h54, 8'hA3, 8'h65, 8'h67};
        logic [11:0] v [10] = '{12'h0FF, 12'hFFF, 12'hFFF, 12'hFFF, 12'h0,
                                12'h0, 12'hFFF, 12'h0FF, 12'h0FF, 12'h0};
        logic [11:0] c [10] = '{12'hFFF, 12'h07F, 12'hFFF, 12'h0, 12'h0,
                                12'h0, 12'h080, 12'hFFF, 12'hFFF, 12'h0};
        logic [11:0] p [10] = '{12'hFFF, 12'hFFF, 12'h0FF, 12'hFFF, 12'h0,
                                12'h0, 12'hFFF, 12'hFFF, 12'hFFF, 12'h0};
        logic [1:0]  code [10] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0,
                                   2'h0, 2'h1, 2'h1, 2'h0};
        wr(8'h04, 32'h1);
        wr(8'h08, 32'h100);
        wr(8'h0C, 32'h100);
        wr(8'h10, 32'h100);
        for (int i = 0; i < 10; i++) begin
            i_fld.set_lv(12'hFFF, 12'hFFF, 12'hFFF);
            wt(3);
            wr(8'h00, 32'(ctl[i]));
            i_fld.set_lv(v[i], c[i], p[i]);
            wt(360);
            check("early", 64'(loss), 64'h0);
            wt(80);
            check("code", 64'(loss), 64'(code[i]));
            rdc(8'h28, {29'h0, code[i] != 2'h0, code[i]});
            check("drive", 64'(drive_on),
                  64'(!(code[i] != 0 && ctl[i][7:6] == 2'h1)));
            check("decel", 64'(decel),
                  64'(code[i] != 0 && ctl[i][7:6] == 2'h2));
        end
        wr(8'h00, 32'h62);
        wt(300);
        i_fld.set_lv(12'hFFF, 12'hFFF, 12'hFFF);
        wt(8);
        i_fld.set_lv(12'h0FF, 12'hFFF, 12'hFFF);
        wt(360);
        check("restart", 64'(loss), 64'h0);
        wt(80);
        check("late", 64'(loss), 64'h1);
    endtask : t_loss
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_levels();
        t_jog();
        t_funcs();
        t_loss();
        summarize();
    end
endmodule : rli_top_bench
`default_nettype wire
